// *** rtl/cdram_host.sv ***
`timescale 1ns/1ps
// Operation
// - Read: row strobe falls, select low, we_r low
// - Read hit allows early row strobe rise; the host never rises early and always waits out LOW_CNT
// - Write: write_not_read, refresh high, latches high
// - Column latch then write strobe low
// - Drive bank selects separately, never tied
// - No row strobe on deselected bank; refresh and self refresh strobe with both selects high
// - Self refresh entry pin pattern
// - Refresh request: 1024 per 64ms
module cdram_host #(
    parameter int REFRESH_GAP = cdram_host_pkg::REFRESH_GAP_CYC
) (
    input  wire logic                    clk_in,          // Clock
    input  wire logic                    reset_n_in,      // Async reset
    input  wire logic                    req_valid_in,    // Request
    output logic                         req_ready_out,   // Request taken
    input  wire logic [1:0]              req_cmd_in,      // Command
    input  wire logic                    req_bank_in,     // Bank
    input  wire logic [10:0]             req_row_in,      // Row
    input  wire logic [8:0]              req_col_in,      // Column
    input  wire logic [31:0]             req_wdata_in,    // Write data
    output logic                         rsp_valid_out,   // Read data pulse
    output logic [31:0]                  rsp_rdata_out,   // Read data
    output logic [1:0]                   row_strobe_n_out,// Per bank
    output logic [1:0]                   bank_sel_n_out,  // Per bank
    output logic                         write_not_read_out, // W/R
    output logic                         refresh_n_out,   // Refresh req
    output logic                         col_latch_n_out, // Column latch
    output logic                         write_n_out,     // Write strobe
    output logic                         gate_n_out,      // Output gate
    output logic [10:0]                  mux_address_out, // Address
    input  wire logic [31:0]             dq_in,           // Data in
    output logic [31:0]                  dq_out,          // Data out
    output logic                         dq_oe_out        // Data enable
);

    // ********************************************************
    // Parameter check
    // ********************************************************
    if (REFRESH_GAP < 2 * (cdram_host_pkg::ROW_LOW_CYC
                         + cdram_host_pkg::PRECHARGE_CYC + 4))
        $error("REFRESH_GAP too small");

    localparam logic [7:0] LOW_CNT = 8'(cdram_host_pkg::ROW_LOW_CYC);
    localparam logic [7:0] PRE_CNT = 8'(cdram_host_pkg::PRECHARGE_CYC);

    typedef enum logic [3:0] {
        ST_IDLE, ST_SETUP, ST_ROW, ST_COL, ST_DATA, ST_WSTRB,
        ST_RISE, ST_PRE, ST_SELF
    } state_e;

    state_e        state_r;
    logic  [7:0]   cnt_r;
    logic  [31:0]  ref_cnt_r;
    logic          ref_due_r;
    logic          is_ref_r;
    logic  [1:0]   cmd_r;
    logic          bank_r;
    logic  [10:0]  row_r;
    logic  [8:0]   col_r;
    logic  [31:0]  wdata_r;

    function automatic logic [1:0] bank_onehot_n(input logic b);
        bank_onehot_n = b ? 2'h1 : 2'h2;
    endfunction : bank_onehot_n

    assign req_ready_out = (state_r == ST_IDLE) && !ref_due_r;

    // ********************************************************
    // Refresh scheduler
    // ********************************************************
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ref_cnt_r <= 32'h0;
            ref_due_r <= 1'b0;
        end
        else
        begin
            if (ref_cnt_r >= 32'(REFRESH_GAP - 1))
                ref_cnt_r <= 32'h0;
            else
                ref_cnt_r <= ref_cnt_r + 32'h1;
            // Set wins over clear
            if (ref_cnt_r >= 32'(REFRESH_GAP - 1))
                ref_due_r <= 1'b1;
            else if (state_r == ST_IDLE && ref_due_r)
                ref_due_r <= 1'b0;
        end
    end

    // ********************************************************
    // Cycle sequencer
    // ********************************************************
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_r  <= ST_IDLE;
            cnt_r    <= 8'h0;
            is_ref_r <= 1'b0;
            cmd_r    <= 2'h0;
            bank_r   <= 1'b0;
            row_r    <= 11'h0;
            col_r    <= 9'h0;
            wdata_r  <= 32'h0;
        end
        else
        begin
            cnt_r <= (cnt_r != 8'h0) ? cnt_r - 8'h1 : 8'h0;
            unique case (state_r)
                ST_IDLE:
                begin
                    if (ref_due_r)
                    begin
                        is_ref_r <= 1'b1;
                        state_r  <= ST_SETUP;
                    end
                    else if (req_valid_in)
                    begin
                        is_ref_r <= 1'b0;
                        cmd_r    <= req_cmd_in;
                        bank_r   <= req_bank_in;
                        row_r    <= req_row_in;
                        col_r    <= req_col_in;
                        wdata_r  <= req_wdata_in;
                        state_r  <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    cnt_r   <= LOW_CNT;
                    state_r <= is_ref_r ? ST_RISE :
                               (cmd_r == cdram_host_pkg::CMD_SELFREF)
                               ? ST_SELF : ST_ROW;
                end
                ST_ROW:
                    state_r <= ST_COL;
                ST_COL:
                    state_r <= (cmd_r == cdram_host_pkg::CMD_WRITE)
                               ? ST_WSTRB : ST_DATA;
                ST_DATA:
                    state_r <= ST_RISE;
                ST_WSTRB:
                    state_r <= ST_RISE;
                ST_RISE:
                begin
                    if (cnt_r == 8'h0)
                    begin
                        cnt_r   <= PRE_CNT;
                        state_r <= ST_PRE;
                    end
                end
                ST_SELF:
                begin
                    if (req_valid_in && cnt_r == 8'h0)
                    begin
                        cnt_r   <= PRE_CNT;
                        state_r <= ST_PRE;
                    end
                end
                ST_PRE:
                    if (cnt_r == 8'h0)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ********************************************************
    // Pin drivers
    // ********************************************************
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            row_strobe_n_out   <= 2'h3;
            bank_sel_n_out     <= 2'h3;
            write_not_read_out <= 1'b0;
            refresh_n_out      <= 1'b1;
            col_latch_n_out    <= 1'b1;
            write_n_out        <= 1'b1;
            gate_n_out         <= 1'b1;
            mux_address_out    <= 11'h0;
            dq_out             <= 32'h0;
            dq_oe_out          <= 1'b0;
        end
        else
        begin
            col_latch_n_out <= 1'b1;
            write_n_out     <= 1'b1;
            gate_n_out      <= 1'b1;
            dq_oe_out       <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    row_strobe_n_out <= 2'h3;
                    bank_sel_n_out   <= 2'h3;
                end
                ST_SETUP:
                begin
                    refresh_n_out      <= !is_ref_r;
                    // Select ahead of strobe, one bank only
                    bank_sel_n_out     <= is_ref_r ? 2'h3 :
                        (cmd_r == cdram_host_pkg::CMD_SELFREF) ? 2'h3 :
                        bank_onehot_n(bank_r);
                    write_not_read_out <= (cmd_r != cdram_host_pkg::CMD_READ)
                                          && !is_ref_r;
                    col_latch_n_out    <= !(cmd_r == cdram_host_pkg::CMD_SELFREF
                                            && !is_ref_r);
                    mux_address_out    <= row_r;
                end
                ST_ROW:
                begin
                    // Falls only on selected bank
                    row_strobe_n_out <= bank_onehot_n(bank_r);
                end
                ST_COL:
                begin
                    mux_address_out <= {2'h0, col_r};
                    col_latch_n_out <= 1'b0;
                    dq_out          <= wdata_r;
                    dq_oe_out       <= (cmd_r == cdram_host_pkg::CMD_WRITE);
                    gate_n_out      <= (cmd_r == cdram_host_pkg::CMD_WRITE);
                end
                ST_WSTRB:
                begin
                    // Column latch stays low, write needs both low
                    col_latch_n_out <= 1'b0;
                    dq_oe_out       <= 1'b1;
                    write_n_out     <= 1'b0;
                end
                ST_DATA:
                    gate_n_out <= 1'b0;
                ST_RISE:
                begin
                    // Refresh strobes both banks, select off
                    if (is_ref_r)
                        row_strobe_n_out <= 2'h0;
                    else if (cmd_r == cdram_host_pkg::CMD_SELFREF)
                        row_strobe_n_out <= bank_onehot_n(bank_r);
                end
                ST_SELF:
                begin
                    // Column latch held low through the strobe fall
                    col_latch_n_out  <= 1'b0;
                    row_strobe_n_out <= bank_onehot_n(bank_r);
                end
                ST_PRE:
                begin
                    // Deselect with the strobe rise, idle is standby
                    row_strobe_n_out <= 2'h3;
                    bank_sel_n_out   <= 2'h3;
                    refresh_n_out    <= 1'b1;
                end
                default:
                    row_strobe_n_out <= 2'h3;
            endcase
        end
    end

    // ********************************************************
    // Read data capture
    // ********************************************************
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 32'h0;
        end
        else
        begin
            rsp_valid_out <= (state_r == ST_RISE) && !is_ref_r
                             && (cmd_r == cdram_host_pkg::CMD_READ)
                             && (cnt_r == LOW_CNT - 8'h3);
            if ((state_r == ST_RISE) && (cnt_r == LOW_CNT - 8'h3))
                rsp_rdata_out <= dq_in;
        end
    end

endmodule : cdram_host

// *** rtl/cdram_host_pkg.sv ***
package cdram_host_pkg;

    // ********************************************************
    // Pin and cycle constants
    // ********************************************************
    localparam int ROW_BITS          = 11;
    localparam int COL_BITS          = 9;
    localparam int DATA_BITS         = 32;
    localparam int CLK_PERIOD_PS     = 4000;
    // Least row strobe low time and precharge time
    localparam int ROW_LOW_NS        = 30;
    localparam int PRECHARGE_NS      = 20;
    localparam int ROW_LOW_CYC       = (ROW_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int PRECHARGE_CYC     = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    // Refresh: 1024 cycles every 64 ms
    localparam int REFRESH_ROWS      = 1024;
    localparam int REFRESH_PERIOD_US = 64000;
    // Cycles per microsecond first, keeps the product inside 32 bits
    localparam int REFRESH_GAP_CYC   = REFRESH_PERIOD_US
                                       * (1000000 / CLK_PERIOD_PS)
                                       / REFRESH_ROWS;

    // Request commands
    localparam logic [1:0] CMD_READ    = 2'h0;
    localparam logic [1:0] CMD_WRITE   = 2'h1;
    localparam logic [1:0] CMD_SELFREF = 2'h2;

endpackage : cdram_host_pkg

// *** test/cdram_device.sv ***
`timescale 1ns/1ps
// ****************************************
// Cached memory device model
// ****************************************
module cdram_device (
    input  wire logic        clk_in,             // Clock
    input  wire logic [1:0]  row_strobe_n_out,   // Strobes
    input  wire logic [1:0]  bank_sel_n_out,     // Selects
    input  wire logic        write_not_read_out, // W/R
    input  wire logic        refresh_n_out,      // Refresh
    input  wire logic        col_latch_n_out,    // Column latch
    input  wire logic        write_n_out,        // Write strobe
    input  wire logic        gate_n_out,         // Gate
    input  wire logic [10:0] mux_address_out,    // Address
    input  wire logic [31:0] dq_out,             // Host data
    output logic      [31:0] dq_in               // Device data
);
    logic [31:0] mem [int];
    logic [10:0] last_row_tag [2] = '{11'h0, 11'h0};
    logic [10:0] wrow;
    logic [8:0]  col;
    logic [1:0]  rs_q = 2'h3;
    logic        cl_q = 1'b1, we_q = 1'b1, wact = 1'b0, wmiss, wb, b;
    logic [31:0] last_q = 32'h0;
    int          key;
    int          refresh_row = 0;
    // Array row equals cache row for the tagged row
    always @*
    begin
        b = bank_sel_n_out[0];
        key = int'({b, last_row_tag[b],
            col_latch_n_out ? mux_address_out[8:0] : col});
        dq_in = ~last_q;
        if (bank_sel_n_out != 2'h3 && !gate_n_out && !(wact && wmiss)
            && mem.exists(key) && last_q == last_q)
            dq_in = mem[key];
    end
    always @(posedge clk_in)
    begin
        for (int i = 0; i < 2; i++)
            if (rs_q[i] && !row_strobe_n_out[i] && !bank_sel_n_out[i]
                && refresh_n_out)
            begin
                if (!write_not_read_out)
                    last_row_tag[i] <= mux_address_out;
                else
                begin
                    wact  <= 1'b1;
                    wb    <= i[0];
                    wrow  <= mux_address_out;
                    wmiss <= mux_address_out != last_row_tag[i];
                end
            end
        if (!refresh_n_out && rs_q == 2'h3 && row_strobe_n_out == 2'h0)
            refresh_row <= refresh_row + 1;
        if (&row_strobe_n_out)
            wact <= 1'b0;
        if (cl_q && !col_latch_n_out)
            col <= mux_address_out[8:0];
        if (we_q && !write_n_out && wact && !col_latch_n_out)
            mem[int'({wb, wrow, col})] = dq_out;
        rs_q   <= row_strobe_n_out;
        cl_q   <= col_latch_n_out;
        we_q   <= write_n_out;
        last_q <= dq_in;
    end
endmodule : cdram_device

// *** test/cdram_host_properties.sv ***
`timescale 1ns/1ps
// ****************************************
// Pin sequence checks
// ****************************************
module cdram_host_properties (
    input  wire logic       clk_in,             // Clock
    input  wire logic       reset_n_in,         // Reset
    input  wire logic       req_valid_in,       // Request
    input  wire logic       req_ready_out,      // Taken
    input  wire logic [1:0] req_cmd_in,         // Command
    input  wire logic       rsp_valid_out,      // Read data
    input  wire logic [1:0] row_strobe_n_out,   // Strobes
    input  wire logic [1:0] bank_sel_n_out,     // Selects
    input  wire logic       write_not_read_out, // W/R
    input  wire logic       refresh_n_out,      // Refresh
    input  wire logic       col_latch_n_out,    // Column latch
    input  wire logic       write_n_out,        // Write strobe
    input  wire logic       dq_oe_out           // Data enable
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    for (genvar i = 0; i < 2; i++)
    begin : bk
        read_entry_a: assert property ($fell(row_strobe_n_out[i])
            && !write_not_read_out && refresh_n_out
            |-> !bank_sel_n_out[i] && col_latch_n_out) else $error("read entry");
        write_entry_a: assert property ($fell(row_strobe_n_out[i])
            && write_not_read_out && refresh_n_out && !bank_sel_n_out[i]
            |-> col_latch_n_out && write_n_out) else $error("write entry");
        self_ref_a: assert property ($fell(row_strobe_n_out[i])
            && bank_sel_n_out[i] && refresh_n_out
            |-> write_not_read_out && write_n_out && !col_latch_n_out)
            else $error("strobe on idle bank");
    end
    one_bank_a: assert property (bank_sel_n_out != 2'h0)
        else $error("both banks selected");
    host_drive_a: assert property (dq_oe_out |-> write_not_read_out)
        else $error("data driven outside write");
    wr_strobe_a: assert property ($fell(write_n_out) |->
        !col_latch_n_out && dq_oe_out) else $error("write strobe early");
    refresh_pins_a: assert property ($fell(refresh_n_out) |->
        ##[0:2] row_strobe_n_out == 2'h0) else $error("refresh strobes");
    read_answer_a: assert property (req_valid_in && req_ready_out
        && req_cmd_in == 2'h0 |-> ##[3:40] rsp_valid_out)
        else $error("read answer late");
    idle_standby_a: assert property (req_ready_out |->
        bank_sel_n_out == 2'h3) else $error("select left on");
    cover property ($fell(refresh_n_out));
    cover property (req_valid_in && req_ready_out && req_cmd_in == 2'h1);
    cover property ($fell(row_strobe_n_out[0]) && bank_sel_n_out[0]);
endmodule : cdram_host_properties

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        clk_in, reset_n_in, req_valid_in, req_ready_out, req_bank_in;
    logic [1:0]  req_cmd_in, row_strobe_n_out, bank_sel_n_out;
    logic [10:0] req_row_in, mux_address_out, ra, rb;
    logic [8:0]  req_col_in, ca, cb;
    logic [31:0] req_wdata_in, rsp_rdata_out, dq_in, dq_out;
    logic        rsp_valid_out, write_not_read_out, refresh_n_out;
    logic        col_latch_n_out, write_n_out, gate_n_out, dq_oe_out;
    logic [31:0] exp_q [$];
    logic [31:0] ref_mem [int];
    int          errors = 0, checks = 0, seed = 32'h3aca;
    cdram_host #(.REFRESH_GAP(64)) uut (.clk_in, .reset_n_in, .req_valid_in,
        .req_ready_out, .req_cmd_in, .req_bank_in, .req_row_in, .req_col_in,
        .req_wdata_in, .rsp_valid_out, .rsp_rdata_out, .row_strobe_n_out,
        .bank_sel_n_out, .write_not_read_out, .refresh_n_out,
        .col_latch_n_out, .write_n_out, .gate_n_out, .mux_address_out,
        .dq_in, .dq_out, .dq_oe_out);
    cdram_device dev (.clk_in, .row_strobe_n_out, .bank_sel_n_out,
        .write_not_read_out, .refresh_n_out, .col_latch_n_out, .write_n_out,
        .gate_n_out, .mux_address_out, .dq_out, .dq_in);
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (e !== g || $isunknown(g))
        begin
            errors++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic req(input logic [1:0] c, input logic b,
                       input logic [10:0] r, input logic [8:0] k);
        int n;
        n = 0;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_cmd_in   <= c;
        req_bank_in  <= b;
        req_row_in   <= r;
        req_col_in   <= k;
        req_wdata_in <= $random(seed);
        @(posedge clk_in);
        while (req_ready_out !== 1'b1 && n < 2000)
        begin
            n++;
            @(posedge clk_in);
        end
        if (n >= 2000)
        begin
            errors++;
            end_of_test;
        end
        req_valid_in <= 1'b0;
        if (c == cdram_host_pkg::CMD_WRITE)
            ref_mem[int'({b, r, k})] = req_wdata_in;
        if (c == cdram_host_pkg::CMD_READ)
            exp_q.push_back(ref_mem[int'({b, r, k})]);
    endtask : req
    always @(posedge clk_in)
        if (rsp_valid_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk('x, rsp_rdata_out);
            else
                chk(exp_q.pop_front(), rsp_rdata_out);
        end
    initial
    begin
        #100000;
        errors++;
        end_of_test;
    end
    initial
    begin
        {reset_n_in, req_valid_in, req_bank_in, req_cmd_in} = '0;
        {req_row_in, req_col_in, req_wdata_in} = '0;
        ra = 11'($random(seed));
        rb = ra ^ 11'h401;
        ca = 9'($random(seed));
        cb = ~ca;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            req(cdram_host_pkg::CMD_WRITE, i[0], ra, ca);
            req(cdram_host_pkg::CMD_WRITE, i[0], rb, cb);
            req(cdram_host_pkg::CMD_READ, i[0], ra, ca);
            req(cdram_host_pkg::CMD_READ, i[0], ra, ca);
            req(cdram_host_pkg::CMD_WRITE, i[0], rb, cb);
            req(cdram_host_pkg::CMD_WRITE, i[0], ra, ca);
            req(cdram_host_pkg::CMD_READ, i[0], ra, ca);
            req(cdram_host_pkg::CMD_READ, i[0], rb, cb);
        end
        req(cdram_host_pkg::CMD_READ, 1'b0, ra, ca);
        req(cdram_host_pkg::CMD_SELFREF, 1'b0, ra, ca);
        repeat (20) @(posedge clk_in);
        req(cdram_host_pkg::CMD_READ, 1'b1, rb, cb);
        for (int n = 0; n < 200 && exp_q.size() > 0; n++)
            @(posedge clk_in);
        if (exp_q.size() > 0)
            errors++;
        chk(32'h1, 32'(dev.refresh_row != 0));
        end_of_test;
    end
endmodule : tb
bind cdram_host cdram_host_properties chk_i (.clk_in, .reset_n_in,
    .req_valid_in, .req_ready_out, .req_cmd_in, .rsp_valid_out,
    .row_strobe_n_out, .bank_sel_n_out, .write_not_read_out, .refresh_n_out,
    .col_latch_n_out, .write_n_out, .dq_oe_out);
